/* File: hw/cmsm_pkg.sv */
/*
 * Shared constants for the clock monitor and soft-mute block: register map,
 * field positions, reset values, divider ratios, timeout table and ramp timing.
 * Assumes a single 100 MHz system clock that also stands for the distribution
 * input clock.
 */
package cmsm_pkg;

  // Timing base.
  localparam int CLK_PERIOD_NS        = 10;
  localparam int REF_TICK_NS          = 1000000;
  localparam int MS_TICK_CYCLES_DEF   = REF_TICK_NS / CLK_PERIOD_NS;
  localparam int RAMP_BASE_NS         = 15000;
  localparam int RAMP_BASE_CYCLES_DEF = RAMP_BASE_NS / CLK_PERIOD_NS;
  localparam int MUTE_STEPS_DEF       = 100;

  // Clock tree ratios.
  localparam int PLL_TO_FS_RATIO = 1024;
  localparam int DIV_HALF        = 2;
  localparam int DIV_MOD         = 16;

  //////////////////////////////////////////////////////////////////////////////

  // Register offsets.
  localparam logic [7:0] ADDR_MON_CONFIG  = 8'h00;
  localparam logic [7:0] ADDR_MON_TIMEOUT = 8'h01;
  localparam logic [7:0] ADDR_MUTE_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_FAULT_MASK  = 8'h04;

  // Field positions.
  localparam int MON1_SRC_BIT    = 4;
  localparam int MON2_SRC_LSB    = 2;
  localparam int MON1_EN_BIT     = 1;
  localparam int MON2_EN_BIT     = 0;
  localparam int MON1_TIME_LSB   = 3;
  localparam int MON2_TIME_LSB   = 0;
  localparam int RAMP_RATE_LSB   = 6;
  localparam int FLAG_MON1_BIT   = 0;
  localparam int FLAG_MON2_BIT   = 1;

  // Reset values.
  localparam logic [7:0] RST_MON_CONFIG  = 8'h03;
  localparam logic [7:0] RST_MON_TIMEOUT = 8'h3F;
  localparam logic [7:0] RST_MUTE_CONFIG = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK  = 8'h00;

  // Detector two source codes.
  localparam logic [1:0] SRC2_PLAYBACK = 2'h0;
  localparam logic [1:0] SRC2_SENSE    = 2'h1;
  localparam logic [1:0] SRC2_PLL      = 2'h2;

  // Timeout table in milliseconds.
  localparam logic [10:0] TIMEOUT_MS_0 = 11'h00B;
  localparam logic [10:0] TIMEOUT_MS_1 = 11'h016;
  localparam logic [10:0] TIMEOUT_MS_2 = 11'h02C;
  localparam logic [10:0] TIMEOUT_MS_3 = 11'h057;
  localparam logic [10:0] TIMEOUT_MS_4 = 11'h0AE;
  localparam logic [10:0] TIMEOUT_MS_5 = 11'h15E;
  localparam logic [10:0] TIMEOUT_MS_6 = 11'h2BC;
  localparam logic [10:0] TIMEOUT_MS_7 = 11'h4B0;

  typedef enum logic [1:0] {
    CMSM_RUN,
    CMSM_RAMP_DOWN,
    CMSM_MUTED,
    CMSM_RAMP_UP
  } cmsm_mute_state_t;

  function automatic logic [10:0] cmsm_timeout_ms(input logic [2:0] sel);
    logic [10:0] ms;
    ms = TIMEOUT_MS_7;
    case (sel)
      3'h0: ms = TIMEOUT_MS_0;
      3'h1: ms = TIMEOUT_MS_1;
      3'h2: ms = TIMEOUT_MS_2;
      3'h3: ms = TIMEOUT_MS_3;
      3'h4: ms = TIMEOUT_MS_4;
      3'h5: ms = TIMEOUT_MS_5;
      3'h6: ms = TIMEOUT_MS_6;
      default: ms = TIMEOUT_MS_7;
    endcase
    return ms;
  endfunction : cmsm_timeout_ms

endpackage : cmsm_pkg

/* File: hw/cmsm_detector.sv */
/*
 * One clock-loss detector: counts millisecond reference ticks since the last
 * observed edge of its monitored clock and flags a fault past the limit.
 * Assumes edge_in and ms_tick_in are one-cycle pulses on clk_in.
 */
`timescale 1ns/1ps
module cmsm_detector
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Control
  input  wire logic        enable_in,
  input  wire logic [10:0] limit_ms_in,
  // Events
  input  wire logic        edge_in,
  input  wire logic        ms_tick_in,
  // Result
  output logic             fault_out
);

  logic [10:0] elapsed_ms;

  // The counter saturates so a long outage never wraps back below the limit.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in || !enable_in || edge_in)
      elapsed_ms <= 11'h000;
    else if (ms_tick_in && elapsed_ms != 11'h7FF)
      elapsed_ms <= elapsed_ms + 11'h001;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in || !enable_in || edge_in)
      fault_out <= 1'b0;
    else
      fault_out <= (elapsed_ms >= limit_ms_in);
  end

endmodule : cmsm_detector

/* File: hw/cmsm_clock_monitor.sv */
/*
 * Clock distribution enables, two clock-loss detectors, the fault soft-mute
 * ramp and the byte register file that configures them.
 * Assumes clk_in is the distribution input clock, that the monitored clock
 * inputs are synchronous to it, and that an outside serial-control slave
 * turns bus transactions into the byte register strobes used here.
 */
`timescale 1ns/1ps
module cmsm_clock_monitor
#(
  parameter int MS_TICK_CYCLES   = cmsm_pkg::MS_TICK_CYCLES_DEF,
  parameter int RAMP_BASE_CYCLES = cmsm_pkg::RAMP_BASE_CYCLES_DEF,
  parameter int MUTE_STEPS       = cmsm_pkg::MUTE_STEPS_DEF
)
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Monitored clocks, sampled on clk_in
  input  wire logic       audio_port_bit_clock_in,
  input  wire logic       pulse_density_clock_in,
  input  wire logic       pll_clock_in,
  // Register strobes
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // Clock distribution enables
  output logic            half_rate_node_tick_out,
  output logic            playback_modulator_tick_out,
  output logic            sense_modulator_tick_out,
  // Playback mute control
  output logic      [6:0] mute_attenuation_out,
  output logic            playback_muted_out,
  // Interrupt pin
  output logic            irq_out
);

  logic [7:0]                 clock_monitor_config;
  logic [7:0]                 clock_monitor_timeout;
  logic [7:0]                 clock_fault_mute_config;
  logic [7:0]                 fault_mask;
  logic [1:0]                 fault_flag_register;
  logic [3:0]                 div_count;
  logic [23:0]                ms_count;
  logic                       ms_tick;
  logic                       port_clk_q;
  logic                       pulse_density_clock_q;
  logic                       pll_clk_q;
  logic                       mon1_edge;
  logic                       mon2_edge;
  logic                       mon1_fault;
  logic                       mon2_fault;
  logic                       fault_any;
  logic                       flags_read;
  logic [23:0]                step_count;
  logic [23:0]                step_len;
  logic                       step_tick;
  cmsm_pkg::cmsm_mute_state_t mute_state;

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      clock_monitor_config    <= cmsm_pkg::RST_MON_CONFIG;
      clock_monitor_timeout   <= cmsm_pkg::RST_MON_TIMEOUT;
      clock_fault_mute_config <= cmsm_pkg::RST_MUTE_CONFIG;
      fault_mask              <= cmsm_pkg::RST_FAULT_MASK;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == cmsm_pkg::ADDR_MON_CONFIG)
        clock_monitor_config <= {3'h0, reg_wdata_in[4:0]};
      else if (reg_addr_in == cmsm_pkg::ADDR_MON_TIMEOUT)
        clock_monitor_timeout <= {2'h0, reg_wdata_in[5:0]};
      else if (reg_addr_in == cmsm_pkg::ADDR_MUTE_CONFIG)
        clock_fault_mute_config <= {reg_wdata_in[7:6], 6'h00};
      else if (reg_addr_in == cmsm_pkg::ADDR_FAULT_MASK)
        fault_mask <= {6'h00, reg_wdata_in[1:0]};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      if (reg_addr_in == cmsm_pkg::ADDR_MON_CONFIG)
        reg_rdata_out <= clock_monitor_config;
      else if (reg_addr_in == cmsm_pkg::ADDR_MON_TIMEOUT)
        reg_rdata_out <= clock_monitor_timeout;
      else if (reg_addr_in == cmsm_pkg::ADDR_MUTE_CONFIG)
        reg_rdata_out <= clock_fault_mute_config;
      else if (reg_addr_in == cmsm_pkg::ADDR_FAULT_FLAGS)
        reg_rdata_out <= {6'h00, fault_flag_register};
      else if (reg_addr_in == cmsm_pkg::ADDR_FAULT_MASK)
        reg_rdata_out <= fault_mask;
      else
        reg_rdata_out <= 8'h00;
    end
  end

  assign flags_read = reg_rd_in && (reg_addr_in == cmsm_pkg::ADDR_FAULT_FLAGS);

  // A fault present in the clearing cycle keeps its flag set.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      fault_flag_register <= 2'h0;
    else
      fault_flag_register <= (fault_flag_register & {2{!flags_read}}) |
                             {mon2_fault, mon1_fault};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(fault_flag_register & fault_mask[1:0]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock distribution enables

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      div_count                   <= 4'h0;
      half_rate_node_tick_out     <= 1'b0;
      playback_modulator_tick_out <= 1'b0;
      sense_modulator_tick_out    <= 1'b0;
    end
    else
    begin
      div_count                   <= div_count + 4'h1;
      half_rate_node_tick_out     <= (32'(div_count) % cmsm_pkg::DIV_HALF) ==
                                     (cmsm_pkg::DIV_HALF - 1);
      playback_modulator_tick_out <= 32'(div_count) == (cmsm_pkg::DIV_MOD - 1);
      sense_modulator_tick_out    <= 32'(div_count) == (cmsm_pkg::DIV_MOD - 1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond reference and edge detection

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in || ms_tick)
      ms_count <= 24'h000000;
    else
      ms_count <= ms_count + 24'h000001;
  end

  assign ms_tick = (ms_count == 24'(MS_TICK_CYCLES - 1));

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      {port_clk_q, pulse_density_clock_q, pll_clk_q} <= 3'h0;
    else
      {port_clk_q, pulse_density_clock_q, pll_clk_q} <= {audio_port_bit_clock_in, pulse_density_clock_in,
                                             pll_clock_in};
  end

  always_comb
  begin
    if (clock_monitor_config[cmsm_pkg::MON1_SRC_BIT])
      mon1_edge = pulse_density_clock_in && !pulse_density_clock_q;
    else
      mon1_edge = audio_port_bit_clock_in && !port_clk_q;
  end

  // The reserved source code falls back to the playback modulator.
  always_comb
  begin
    case (clock_monitor_config[cmsm_pkg::MON2_SRC_LSB +: 2])
      cmsm_pkg::SRC2_SENSE: mon2_edge = sense_modulator_tick_out;
      cmsm_pkg::SRC2_PLL:   mon2_edge = pll_clock_in && !pll_clk_q;
      default:              mon2_edge = playback_modulator_tick_out;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Detectors

  cmsm_detector u_mon1
  (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .enable_in   (clock_monitor_config[cmsm_pkg::MON1_EN_BIT]),
    .limit_ms_in (cmsm_pkg::cmsm_timeout_ms(
                    clock_monitor_timeout[cmsm_pkg::MON1_TIME_LSB +: 3])),
    .edge_in     (mon1_edge),
    .ms_tick_in  (ms_tick),
    .fault_out   (mon1_fault)
  );

  cmsm_detector u_mon2
  (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .enable_in   (clock_monitor_config[cmsm_pkg::MON2_EN_BIT]),
    .limit_ms_in (cmsm_pkg::cmsm_timeout_ms(
                    clock_monitor_timeout[cmsm_pkg::MON2_TIME_LSB +: 3])),
    .edge_in     (mon2_edge),
    .ms_tick_in  (ms_tick),
    .fault_out   (mon2_fault)
  );

  assign fault_any = mon1_fault || mon2_fault;

  //////////////////////////////////////////////////////////////////////////////
  // Soft-mute ramp

  // The same rate is used going up, so the return is as smooth as the fade.
  assign step_len  = 24'(RAMP_BASE_CYCLES) <<
                     clock_fault_mute_config[cmsm_pkg::RAMP_RATE_LSB +: 2];
  assign step_tick = (step_count >= step_len - 24'h000001);

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in || step_tick ||
        mute_state == cmsm_pkg::CMSM_RUN || mute_state == cmsm_pkg::CMSM_MUTED)
      step_count <= 24'h000000;
    else
      step_count <= step_count + 24'h000001;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      mute_state           <= cmsm_pkg::CMSM_RUN;
      mute_attenuation_out <= 7'h00;
      playback_muted_out   <= 1'b0;
    end
    else
    begin
      playback_muted_out <= (mute_state == cmsm_pkg::CMSM_MUTED);
      case (mute_state)
        cmsm_pkg::CMSM_RUN:
          if (fault_any)
            mute_state <= cmsm_pkg::CMSM_RAMP_DOWN;
        // End stops are tested after the fault check and before the step: a reversal can land on one before any step.
        cmsm_pkg::CMSM_RAMP_DOWN:
          if (!fault_any)
            mute_state <= cmsm_pkg::CMSM_RAMP_UP;
          else if (mute_attenuation_out == 7'(MUTE_STEPS))
            mute_state <= cmsm_pkg::CMSM_MUTED;
          else if (step_tick)
          begin
            mute_attenuation_out <= mute_attenuation_out + 7'h01;
            if (mute_attenuation_out == 7'(MUTE_STEPS - 1))
              mute_state <= cmsm_pkg::CMSM_MUTED;
          end
        cmsm_pkg::CMSM_MUTED:
          if (!fault_any)
            mute_state <= cmsm_pkg::CMSM_RAMP_UP;
        default:
          if (fault_any)
            mute_state <= cmsm_pkg::CMSM_RAMP_DOWN;
          else if (mute_attenuation_out == 7'h00)
            mute_state <= cmsm_pkg::CMSM_RUN;
          else if (step_tick)
          begin
            mute_attenuation_out <= mute_attenuation_out - 7'h01;
            if (mute_attenuation_out == 7'h01)
              mute_state <= cmsm_pkg::CMSM_RUN;
          end
      endcase
    end
  end

endmodule : cmsm_clock_monitor

/* File: bench/cmsm_clock_sources.sv */
/*
 * Model of the far-side clock sources: serial port, PDM and PLL clocks.
 * Assumes the bench drives the run inputs on clk_in; a stopped clock stays low.
 */
`timescale 1ns/1ps
module cmsm_clock_sources
(
  // Clock
  input  wire logic clk_in,
  // Run controls
  input  wire logic run_port_in,
  input  wire logic run_pdm_in,
  input  wire logic run_pll_in,
  // Clocks
  output logic      port_clk_out,
  output logic      pulse_density_clock_out,
  output logic      pll_clk_out
);
  logic [1:0] div = 2'h0;
  initial {port_clk_out, pulse_density_clock_out, pll_clk_out} = 3'h0;
  always @(posedge clk_in)
  begin
    div          <= div + 2'h1;
    port_clk_out <= run_port_in & div[1];
    pulse_density_clock_out  <= run_pdm_in & div[0];
    pll_clk_out  <= run_pll_in & div[0];
  end
endmodule : cmsm_clock_sources

/* File: bench/cmsm_clock_monitor_chk.sv */
/*
 * Port-level checker for the clock monitor and soft-mute block.
 * Assumes it is bound to the top module with the same parameter values.
 */
`timescale 1ns/1ps
module cmsm_clock_monitor_chk
#(
  parameter int MS_TICK_CYCLES   = 10,
  parameter int RAMP_BASE_CYCLES = 4,
  parameter int MUTE_STEPS       = 4
)
(
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic       audio_port_bit_clock_in,
  input wire logic       pulse_density_clock_in,
  input wire logic       pll_clock_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       half_rate_node_tick_out,
  input wire logic       playback_modulator_tick_out,
  input wire logic       sense_modulator_tick_out,
  input wire logic [6:0] mute_attenuation_out,
  input wire logic       playback_muted_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////
  AST_HALF_TICK: assert property (half_rate_node_tick_out |=>
    !half_rate_node_tick_out ##1 half_rate_node_tick_out) else $error("half tick period");
  AST_MOD_SAME: assert property (playback_modulator_tick_out ==
    sense_modulator_tick_out) else $error("modulator ticks differ");
  AST_MOD_PERIOD: assert property (playback_modulator_tick_out |=>
    !playback_modulator_tick_out[*8] ##8 playback_modulator_tick_out) else $error("mod period");
  AST_ATT_STEP: assert property ($changed(mute_attenuation_out) |->
    (mute_attenuation_out == $past(mute_attenuation_out) + 7'h01
    || mute_attenuation_out == $past(mute_attenuation_out) - 7'h01)) else $error("att step");
  AST_ATT_SPACING: assert property ($changed(mute_attenuation_out) |=>
    $stable(mute_attenuation_out)[*3]) else $error("att steps too close");
  AST_ATT_MAX: assert property (mute_attenuation_out <= 7'(MUTE_STEPS))
    else $error("att above full mute");
  AST_MUTED_MAX: assert property (playback_muted_out |->
    mute_attenuation_out == 7'(MUTE_STEPS)) else $error("muted below full att");
  AST_RDATA_HOLD: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  AST_IRQ_MASK: assert property (reg_wr_in && reg_addr_in == cmsm_pkg::ADDR_FAULT_MASK
    && reg_wdata_in[1:0] == 2'h0 ##1 !(reg_wr_in && reg_addr_in == cmsm_pkg::ADDR_FAULT_MASK)
    |=> !irq_out) else $error("irq despite mask");
  COV_MUTED: cover property ($rose(playback_muted_out));
  COV_IRQ: cover property ($rose(irq_out));
  COV_UNMUTE: cover property ($fell(playback_muted_out));
endmodule : cmsm_clock_monitor_chk

/* File: bench/cmsm_clock_monitor_bench.sv */
/*
 * Self-checking bench for the clock monitor: register tasks, clock stops.
 * Assumes the clock source model and short tick, ramp and mute parameters.
 */
`timescale 1ns/1ps
module cmsm_clock_monitor_bench;
  logic       clk_in       = 1'b0;
  logic       rst_b_in     = 1'b0;
  logic [7:0] reg_addr_in  = 8'h00;
  logic       reg_wr_in    = 1'b0;
  logic       reg_rd_in    = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       run_port     = 1'b1;
  logic       run_pdm      = 1'b1;
  logic       run_pll      = 1'b1;
  logic       port_clk, pulse_density_clock, pll_clk, half, play, irq_out, muted;
  logic [7:0] rdata;
  logic [6:0] att;
  int         failures     = 0;
  int         total_checks = 0;
  int         n_half       = 0;
  int         n_mod        = 0;
  int         n;
  int         m;
  logic [7:0] rst_v [6]    = '{8'h03, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00};
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    n_half += int'(half);
    n_mod  += int'(play);
  end
  cmsm_clock_sources src (.clk_in(clk_in), .run_port_in(run_port), .run_pdm_in(run_pdm),
    .run_pll_in(run_pll), .port_clk_out(port_clk), .pulse_density_clock_out(pulse_density_clock),
    .pll_clk_out(pll_clk));
  cmsm_clock_monitor #(.MS_TICK_CYCLES(10), .RAMP_BASE_CYCLES(4), .MUTE_STEPS(4)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .audio_port_bit_clock_in(port_clk),
    .pulse_density_clock_in(pulse_density_clock), .pll_clock_in(pll_clk), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(rdata), .half_rate_node_tick_out(half), .playback_modulator_tick_out(play),
    .sense_modulator_tick_out(), .mute_attenuation_out(att), .playback_muted_out(muted),
    .irq_out(irq_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  function automatic logic [7:0] pick(input int s);
    return s == 0 ? {7'h00, irq_out} : s == 1 ? {7'h00, muted} : {1'b0, att};
  endfunction : pick
  // Bounded wait on irq (0), muted (1) or attenuation (2), then compare.
  task automatic await(input int s, input logic [7:0] v, input int lim);
    for (int i = 0; i < lim && pick(s) !== v; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    chk(pick(s), v);
  endtask : await
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    failures++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int a = 0; a < 6; a++) rd(a[7:0], rst_v[a]);
    n = n_half;
    m = n_mod;
    repeat (32) @(posedge clk_in);
    #1 chk(8'(n_half - n), 8'h10);
    chk(8'(n_mod - m), 8'h02);
    wr(cmsm_pkg::ADDR_MON_CONFIG, 8'h00);
    wr(cmsm_pkg::ADDR_MON_TIMEOUT, 8'h00);
    wr(cmsm_pkg::ADDR_MUTE_CONFIG, 8'hC0);
    rd(cmsm_pkg::ADDR_MUTE_CONFIG, 8'hC0);
    wr(cmsm_pkg::ADDR_FAULT_MASK, 8'h03);
    wr(cmsm_pkg::ADDR_MON_CONFIG, 8'h0B);
    $display("test registers done");
    run_port <= 1'b0;
    repeat (90) @(posedge clk_in);
    #1 chk({7'h00, irq_out}, 8'h00);
    await(0, 8'h01, 60);
    rd(cmsm_pkg::ADDR_FAULT_FLAGS, 8'h01);
    await(2, 8'h01, 300);
    for (n = 0; att === 7'h01 && n < 100; n++)
    begin
      @(posedge clk_in);
      #1;
    end
    chk(8'(n), 8'h20);
    await(1, 8'h01, 300);
    run_port <= 1'b1;
    await(2, 8'h00, 400);
    chk({7'h00, muted}, 8'h00);
    rd(cmsm_pkg::ADDR_FAULT_FLAGS, 8'h01);
    rd(cmsm_pkg::ADDR_FAULT_FLAGS, 8'h00);
    chk({7'h00, irq_out}, 8'h00);
    $display("test detector one done");
    wr(cmsm_pkg::ADDR_MON_CONFIG, 8'h1B);
    run_port <= 1'b0;
    run_pll  <= 1'b0;
    await(0, 8'h01, 200);
    rd(cmsm_pkg::ADDR_FAULT_FLAGS, 8'h02);
    wr(cmsm_pkg::ADDR_FAULT_MASK, 8'h00);
    @(posedge clk_in);
    #1 chk({7'h00, irq_out}, 8'h00);
    await(1, 8'h01, 300);
    run_port <= 1'b1;
    run_pll  <= 1'b1;
    await(2, 8'h00, 400);
    rd(cmsm_pkg::ADDR_FAULT_FLAGS, 8'h02);
    rd(cmsm_pkg::ADDR_FAULT_FLAGS, 8'h00);
    $display("test detector two done");
    wr(cmsm_pkg::ADDR_FAULT_MASK, 8'h03);
    wr(cmsm_pkg::ADDR_MON_CONFIG, 8'h18);
    {run_port, run_pdm, run_pll} <= 3'h0;
    repeat (200) @(posedge clk_in);
    rd(cmsm_pkg::ADDR_FAULT_FLAGS, 8'h00);
    chk({irq_out, att}, 8'h00);
    $display("test disabled done");
    summarize();
  end
endmodule : cmsm_clock_monitor_bench
bind cmsm_clock_monitor cmsm_clock_monitor_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES),
  .RAMP_BASE_CYCLES(RAMP_BASE_CYCLES), .MUTE_STEPS(MUTE_STEPS)) u_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .audio_port_bit_clock_in(audio_port_bit_clock_in),
  .pulse_density_clock_in(pulse_density_clock_in), .pll_clock_in(pll_clock_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .half_rate_node_tick_out(half_rate_node_tick_out),
  .playback_modulator_tick_out(playback_modulator_tick_out),
  .sense_modulator_tick_out(sense_modulator_tick_out),
  .mute_attenuation_out(mute_attenuation_out), .playback_muted_out(playback_muted_out),
  .irq_out(irq_out));
